// file: ivm_consts.vh
// Constants of the interrupt vector mapper
`ifndef IVM_CONSTS_VH
`define IVM_CONSTS_VH

// ==========================================
// Widths
`define IVM_PC_W 13
`define IVM_NUM_W 5
`define IVM_NSRC 25

// ==========================================
// Variants
`define IVM_VAR_SMALL 0
`define IVM_VAR_MID 1
`define IVM_VAR_LARGE 2
`define IVM_BOOT_START 13'h1C00

// ==========================================
// Vector numbers
`define IVM_VEC_RESET 5'h01
`define IVM_VEC_FIRST_IRQ 5'h02
`define IVM_VEC_COUNT 5'h1A
`define IVM_VEC_WDT 5'h07

// ==========================================
// Source index of the watchdog (vector 7)
`define IVM_SRC_WDT 5

// ==========================================
// Register byte offsets
`define IVM_OFF_CTRL 4'h0
`define IVM_OFF_PEND 4'h4
`define IVM_OFF_STAT 4'h8

// ==========================================
// Control register fields
`define IVM_CTRL_VECTOR_TABLE_SELECT_BIT 0
`define IVM_CTRL_WIE_BIT 1
`define IVM_CTRL_WRE_BIT 2
`define IVM_CTRL_RST 3'h0

// ==========================================
// Status register fields
`define IVM_STAT_VALID_BIT 8
`define IVM_STAT_FUSE_BIT 9
`define IVM_PEND_RST 25'h0000000

`endif

// file: ivm_core_model.sv
// Core fetch model that takes and acknowledges vectors
`timescale 1ns/100ps
`default_nettype none
// ==========
// Core model
module ivm_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gie_i,
  input wire logic [3:0] stall_i,
  input wire logic irq_valid_i,
  output logic irq_ack_o
);
  logic [4:0] wait_reg;
  always @(posedge clk_i) begin
    irq_ack_o <= !rst_i && !irq_ack_o && wait_reg == 5'h00 && irq_valid_i && gie_i;
    // Hold off after an ack, the old vector may still show
    if (rst_i || irq_ack_o) wait_reg <= rst_i ? 5'h00 : {1'b0, stall_i} + 5'h01;
    else if (wait_reg != 5'h00) wait_reg <= wait_reg - 5'h01;
  end
endmodule // ivm_core_model
`default_nettype wire

// file: ivm_mapper.v
// Interrupt vector mapper with a classic Wishbone register slave
// How it works
// - Smallest variant one word per vector; largest variant two words.
// - Smallest variant keeps reset and table at fixed low addresses.
// - Boot variants pick reset vector from the boot reset fuse.
// - Boot variants move the table base by the table select bit.
// - Vector 1 at 0x000 is the common reset entry.
// - External requests zero and one map to 0x001 and 0x002.
// - Pin change groups map to 0x003..0x005; watchdog to 0x006.
// - Second 8-bit timer A, B, overflow map to 0x007..0x009.
// - 16-bit timer capture, A, B, overflow map to 0x00A..0x00D.
// - First 8-bit timer A, B, overflow map to 0x00E..0x010.
// - Synchronous serial transfer complete maps to 0x011.
// - Async serial receive, buffer empty, transmit map to 0x012..0x014.
// - Converter, data memory, comparator, two-wire, store ready: 0x015..0x019.
// - Executing the watchdog vector clears its flag; writing one also clears.
// - In combined mode executing the watchdog vector clears its enable.
`timescale 1ns/100ps
`default_nettype none
`include "ivm_consts.vh"

module ivm_mapper #(
  parameter integer VARIANT = `IVM_VAR_SMALL,
  parameter [12:0] BOOT_START = `IVM_BOOT_START
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire boot_reset_fuse_i,
  input wire ext_req_zero_i,
  input wire ext_req_one_i,
  input wire pin_change_group_zero_i,
  input wire pin_change_group_one_i,
  input wire pin_change_group_two_i,
  input wire watchdog_timeout_source_i,
  input wire tmr2_cmpa_i,
  input wire tmr2_cmpb_i,
  input wire tmr2_ovf_i,
  input wire tmr1_capt_i,
  input wire tmr1_cmpa_i,
  input wire tmr1_cmpb_i,
  input wire tmr1_ovf_i,
  input wire tmr0_cmpa_i,
  input wire tmr0_cmpb_i,
  input wire tmr0_ovf_i,
  input wire sync_serial_done_i,
  input wire async_rx_done_i,
  input wire tx_buffer_empty_i,
  input wire async_tx_done_i,
  input wire conv_done_i,
  input wire nonvolatile_data_ready_i,
  input wire comparator_i,
  input wire two_wire_interface_i,
  input wire program_store_ready_i,
  input wire irq_ack_i,
  output wire irq_valid_o,
  output wire [4:0] irq_vector_o,
  output wire [12:0] irq_addr_o,
  output wire [12:0] reset_addr_o,
  output wire wdt_sys_reset_o
);

  // ==========================================
  // Functions

  // Program address of a vector number
  function [12:0] ivm_addr;
    input [12:0] base;
    input [4:0] vnum;
    reg [12:0] off;
    begin
      off = {8'h00, vnum - 5'h01};
      if (VARIANT == `IVM_VAR_LARGE) begin
        off = {off[11:0], 1'b0};
      end
      ivm_addr = base + off;
    end
  endfunction

  // Index of lowest set bit, low number wins
  // Scans downward so the lowest set bit is written last
  function [4:0] ivm_lowest;
    input [24:0] bits;
    integer k;
    begin
      ivm_lowest = 5'h00;
      for (k = 24; k >= 0; k = k - 1) begin
        if (bits[k]) begin
          ivm_lowest = k[4:0];
        end
      end
    end
  endfunction

  // Byte-lane masked write of a 32-bit word
  function [31:0] ivm_lanes;
    input [3:0] sel;
    input [31:0] dat;
    begin
      ivm_lanes = {{8{sel[3]}} & dat[31:24], {8{sel[2]}} & dat[23:16],
                   {8{sel[1]}} & dat[15:8], {8{sel[0]}} & dat[7:0]};
    end
  endfunction

  // ==========================================
  // Request collection
  // Bit k of the request word belongs to vector k+2
  // Request pins are taken as synchronous, one cycle wide or held
  wire [24:0] req_w;

  assign req_w[0] = ext_req_zero_i;
  assign req_w[1] = ext_req_one_i;

  // pin change groups, watchdog bit driven below
  assign req_w[2] = pin_change_group_zero_i;
  assign req_w[3] = pin_change_group_one_i;
  assign req_w[4] = pin_change_group_two_i;

  assign req_w[6] = tmr2_cmpa_i;
  assign req_w[7] = tmr2_cmpb_i;
  assign req_w[8] = tmr2_ovf_i;

  assign req_w[9] = tmr1_capt_i;
  assign req_w[10] = tmr1_cmpa_i;
  assign req_w[11] = tmr1_cmpb_i;
  assign req_w[12] = tmr1_ovf_i;

  assign req_w[13] = tmr0_cmpa_i;
  assign req_w[14] = tmr0_cmpb_i;
  assign req_w[15] = tmr0_ovf_i;

  assign req_w[16] = sync_serial_done_i;

  assign req_w[17] = async_rx_done_i;
  assign req_w[18] = tx_buffer_empty_i;
  assign req_w[19] = async_tx_done_i;

  assign req_w[20] = conv_done_i;
  assign req_w[21] = nonvolatile_data_ready_i;
  assign req_w[22] = comparator_i;
  assign req_w[23] = two_wire_interface_i;
  assign req_w[24] = program_store_ready_i;

  // ==========================================
  // State
  reg [24:0] pend_reg;
  reg [24:0] pend_next;
  reg vector_table_select_reg;
  reg wie_reg;
  reg wie_next;
  reg wre_reg;
  reg valid_reg;
  reg [4:0] vec_reg;
  reg [12:0] addr_reg;
  reg [12:0] rst_addr_reg;
  reg wdt_rst_reg;
  reg ack_reg;
  reg [31:0] dat_reg;

  // Next values of the read word and the presented vector
  reg [31:0] rd_next;
  reg valid_next;
  reg [4:0] vec_next;
  reg [12:0] addr_next;
  reg [12:0] rst_addr_next;

  wire has_boot = (VARIANT != `IVM_VAR_SMALL);
  wire bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge that ends the access, with ack high
  wire bus_wr = bus_req & wb_we_i & ack_reg;
  wire ctrl_wr = bus_wr & (wb_adr_i == `IVM_OFF_CTRL) & wb_sel_i[0];
  wire [31:0] wr_dat = ivm_lanes(wb_sel_i, wb_dat_i);
  wire wdt_flag = pend_reg[`IVM_SRC_WDT];
  // watchdog request only in interrupt modes
  wire wdt_set = watchdog_timeout_source_i & wie_reg;
  assign req_w[`IVM_SRC_WDT] = wdt_set;
  // core ack retires the presented vector
  // Only one source can be retired per cycle, the one on show
  wire take = irq_ack_i & valid_reg;
  wire wdt_taken = take & (vec_reg == `IVM_VEC_WDT);
  wire [24:0] ack_clr = take ? (25'h0000001 << (vec_reg - `IVM_VEC_FIRST_IRQ))
                             : 25'h0000000;
  wire [24:0] sw_clr = (bus_wr && wb_adr_i == `IVM_OFF_PEND) ? wr_dat[24:0]
                                                              : 25'h0000000;

  // Watchdog flag only counts while its enable stands
  wire [24:0] live = pend_reg & ~ack_clr & ~({24'h000000, ~wie_reg} << `IVM_SRC_WDT);
  wire [4:0] low_idx = ivm_lowest(live);
  wire [4:0] low_vec = low_idx + `IVM_VEC_FIRST_IRQ;

  // ==========================================
  // Base selection
  // fixed base without boot area
  wire [12:0] tbl_base = (has_boot && vector_table_select_reg) ? BOOT_START : 13'h0000;
  wire [12:0] rst_base = (has_boot && boot_reset_fuse_i) ? BOOT_START : 13'h0000;

  // ==========================================
  // Pending flags and watchdog enable
  always @* begin
    // set wins over ack and software clear
    pend_next = (pend_reg & ~ack_clr & ~sw_clr) | req_w;
    wie_next = wie_reg;
    if (ctrl_wr) begin
      wie_next = wb_dat_i[`IVM_CTRL_WIE_BIT];
    end
    // combined mode drops the enable
    // Auto clear beats a write in the same cycle, so the reset mode cannot be dodged
    if (wdt_taken && wre_reg) begin
      wie_next = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= `IVM_PEND_RST;
      wie_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      wie_reg <= wie_next;
    end
  end

  // ==========================================
  // Control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      vector_table_select_reg <= 1'b0;
      wre_reg <= 1'b0;
    end else if (ctrl_wr) begin
      vector_table_select_reg <= wb_dat_i[`IVM_CTRL_VECTOR_TABLE_SELECT_BIT];
      wre_reg <= wb_dat_i[`IVM_CTRL_WRE_BIT];
    end
  end

  // ==========================================
  // Watchdog system reset request
  // Plain reset mode, or a second time-out while the flag is still unserved
  wire wdt_rst_next = watchdog_timeout_source_i & wre_reg & (~wie_reg | wdt_flag);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wdt_rst_reg <= 1'b0;
    end else begin
      wdt_rst_reg <= wdt_rst_next;
    end
  end

  // ==========================================
  // Vector presentation
  always @* begin
    valid_next = 1'b0;
    vec_next = `IVM_VEC_RESET;
    // Idle output points at the reset entry
    addr_next = rst_base;
    rst_addr_next = ivm_addr(rst_base, `IVM_VEC_RESET);
    if (|live) begin
      valid_next = 1'b1;
      vec_next = low_vec;
      addr_next = ivm_addr(tbl_base, low_vec);
    end
  end

  // Registered so the core sees a settled vector, at one cycle of latency
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      vec_reg <= `IVM_VEC_RESET;
      addr_reg <= 13'h0000;
      rst_addr_reg <= 13'h0000;
    end else begin
      valid_reg <= valid_next;
      vec_reg <= vec_next;
      addr_reg <= addr_next;
      rst_addr_reg <= rst_addr_next;
    end
  end

  // ==========================================
  // Wishbone slave, one wait state
  always @* begin
    rd_next = 32'h00000000;
    case (wb_adr_i)
      `IVM_OFF_CTRL: begin
        rd_next = {29'h00000000, wre_reg, wie_reg, vector_table_select_reg};
      end
      `IVM_OFF_PEND: begin
        rd_next = {7'h00, pend_reg};
      end
      `IVM_OFF_STAT: begin
        rd_next = {22'h000000, boot_reset_fuse_i, valid_reg, 3'h0, vec_reg};
      end
      default: begin
        // Unmapped reads answer zero, writes there fall away
        rd_next = 32'h00000000;
      end
    endcase
  end

  // Data is latched on the edge that raises ack and stands until the next access
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req && !ack_reg) begin
        dat_reg <= rd_next;
      end
    end
  end

  // ==========================================
  // Outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_valid_o = valid_reg;
  assign irq_vector_o = vec_reg;
  assign irq_addr_o = addr_reg;
  assign reset_addr_o = rst_addr_reg;
  assign wdt_sys_reset_o = wdt_rst_reg;

endmodule // ivm_mapper
`default_nettype wire

// file: ivm_mapper_chk.sv
// Port checker for the vector mapper
`timescale 1ns/100ps
`default_nettype none
// ==========
// Checker
module ivm_mapper_chk #(
  parameter integer VARIANT = 0
) (
  input wire clk_i,
  input wire rst_i,
  input wire ext_req_zero_i,
  input wire tmr0_ovf_i,
  input wire watchdog_timeout_source_i,
  input wire irq_ack_i,
  input wire irq_valid_o,
  input wire [4:0] irq_vector_o,
  input wire [12:0] irq_addr_o,
  input wire [12:0] reset_addr_o,
  input wire wdt_sys_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Watchdog reset request, a single pulse
  sequence wd_rise;
    $rose(wdt_sys_reset_o);
  endsequence
  sequence wd_taken;
    irq_ack_i && irq_valid_o && irq_vector_o == 5'h07;
  endsequence
  reset_entry_a: assert property (VARIANT != 0 || reset_addr_o == 13'h0000)
    else $error("reset entry moved");
  slot_addr_a: assert property (irq_valid_o |-> VARIANT != 0 ||
    irq_addr_o == {8'h00, irq_vector_o} - 13'h0001) else $error("vector slot address");
  vec_range_a: assert property (irq_valid_o |-> irq_vector_o inside {[5'h02:5'h1A]})
    else $error("vector number out of table");
  idle_vec_a: assert property (!irq_valid_o |->
    irq_vector_o == 5'h01 && irq_addr_o == reset_addr_o) else $error("idle output");
  top_prio_a: assert property (ext_req_zero_i |-> ##2 irq_valid_o && irq_vector_o == 5'h02)
    else $error("first request not on top");
  req_latency_a: assert property (!irq_valid_o && tmr0_ovf_i |-> ##2 irq_valid_o &&
    irq_vector_o <= 5'h11) else $error("timer request lost");
  wd_pulse_a: assert property (wd_rise |-> $past(watchdog_timeout_source_i) ##1
    !wdt_sys_reset_o) else $error("watchdog reset pulse");
  wd_clear_a: assert property (wd_taken |=> !irq_valid_o || irq_vector_o != 5'h07)
    else $error("watchdog flag kept");
endmodule // ivm_mapper_chk
bind ivm_mapper ivm_mapper_chk #(.VARIANT(VARIANT)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ext_req_zero_i(ext_req_zero_i), .tmr0_ovf_i(tmr0_ovf_i), .irq_ack_i(irq_ack_i),
  .watchdog_timeout_source_i(watchdog_timeout_source_i), .irq_valid_o(irq_valid_o),
  .irq_vector_o(irq_vector_o), .irq_addr_o(irq_addr_o), .reset_addr_o(reset_addr_o),
  .wdt_sys_reset_o(wdt_sys_reset_o));
`default_nettype wire

// file: ivm_mapper_test.sv
// Self-checking bench for the vector mapper
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench
module ivm_mapper_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0, hit;
  logic [3:0] adr = 4'h0, sel = 4'hF, stall = 4'h0;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic [24:0] req = 25'h0000000;
  int exp_pend = 0, k, err_total = 0, n_tests = 0, seed = 32'h0B411F7C;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_ack_i, irq_valid_o, wdt_sys_reset_o;
  wire [4:0] irq_vector_o;
  wire [12:0] irq_addr_o, reset_addr_o;
  always #2.5 clk_i = ~clk_i;
  ivm_mapper dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .boot_reset_fuse_i(1'b0), .ext_req_zero_i(req[0]), .ext_req_one_i(req[1]),
    .pin_change_group_zero_i(req[2]), .pin_change_group_one_i(req[3]),
    .pin_change_group_two_i(req[4]), .watchdog_timeout_source_i(req[5]),
    .tmr2_cmpa_i(req[6]), .tmr2_cmpb_i(req[7]), .tmr2_ovf_i(req[8]), .tmr1_capt_i(req[9]),
    .tmr1_cmpa_i(req[10]), .tmr1_cmpb_i(req[11]), .tmr1_ovf_i(req[12]), .tmr0_cmpa_i(req[13]),
    .tmr0_cmpb_i(req[14]), .tmr0_ovf_i(req[15]), .sync_serial_done_i(req[16]),
    .async_rx_done_i(req[17]), .tx_buffer_empty_i(req[18]), .async_tx_done_i(req[19]),
    .conv_done_i(req[20]), .nonvolatile_data_ready_i(req[21]), .comparator_i(req[22]),
    .two_wire_interface_i(req[23]), .program_store_ready_i(req[24]), .irq_ack_i(irq_ack_i),
    .irq_valid_o(irq_valid_o), .irq_vector_o(irq_vector_o), .irq_addr_o(irq_addr_o),
    .reset_addr_o(reset_addr_o), .wdt_sys_reset_o(wdt_sys_reset_o));
  ivm_core_model core (.clk_i(clk_i), .rst_i(rst_i), .gie_i(gie), .stall_i(stall),
    .irq_valid_i(irq_valid_o), .irq_ack_o(irq_ack_i));
  task final_report;
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // Bus cycle held until ack is sampled high
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin err_total++; final_report(); end
  endtask
  task pulse(input logic [24:0] m);
    @(posedge clk_i);
    req <= m;
    exp_pend = exp_pend | {7'h00, m};
    @(posedge clk_i);
    req <= 25'h0000000;
  endtask
  // Let the core take every pending vector, then mask it again
  task drain;
    int n;
    gie <= 1'b1;
    n = 0;
    while ((exp_pend != 0 || irq_valid_o !== 1'b0) && n < 400) begin @(posedge clk_i); n++; end
    gie <= 1'b0;
    if (n >= 400) begin err_total++; final_report(); end
  endtask
  // Model: lowest pending request must be the one taken
  always @(posedge clk_i) begin
    if (irq_ack_i === 1'b1 && irq_valid_o === 1'b1) begin
      k = 0;
      while (k < 24 && !exp_pend[k]) k++;
      chk("vector", k + 2, {27'h0, irq_vector_o});
      chk("address", k + 1, {19'h0, irq_addr_o});
      exp_pend[k] = 1'b0;
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0, rdat);
    chk("ctrl_reset", 32'h0, rdat);
    wb(1'b1, 4'h0, 32'h2, rdat);
    for (int i = 0; i < 25; i++) begin
      pulse(25'h1 << i);
      drain();
    end
    for (int i = 0; i < 8; i++) begin
      stall <= 4'($random(seed));
      pulse(25'($random(seed)));
      drain();
    end
    pulse(25'h20);
    wb(1'b0, 4'h8, 32'h0, rdat);
    chk("status", 32'h107, rdat);
    wb(1'b0, 4'h4, 32'h0, rdat);
    chk("pend_set", 32'h20, rdat);
    wb(1'b1, 4'h4, 32'h20, rdat);
    wb(1'b0, 4'h4, 32'h0, rdat);
    chk("pend_clear", 32'h0, rdat);
    exp_pend = 0;
    wb(1'b1, 4'h0, 32'h6, rdat);
    pulse(25'h20);
    drain();
    wb(1'b0, 4'h0, 32'h0, rdat);
    chk("ctrl_auto", 32'h4, rdat);
    pulse(25'h20);
    exp_pend = 0;
    hit = wdt_sys_reset_o;
    repeat (3) begin @(posedge clk_i); hit |= wdt_sys_reset_o; end
    chk("wdt_reset", 32'h1, {31'h0, hit});
    wb(1'b0, 4'hC, 32'h0, rdat);
    chk("unmapped", 32'h0, rdat);
    chk("reset_addr", 32'h0, {19'h0, reset_addr_o});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0, rdat);
    chk("ctrl_rerun", 32'h0, rdat);
    chk("valid_rerun", 32'h0, {31'h0, irq_valid_o});
    pulse(25'h1);
    drain();
    wb(1'b0, 4'h8, 32'h0, rdat);
    chk("status_idle", 32'h1, rdat);
    final_report();
  end
endmodule // ivm_mapper_test
`default_nettype wire
